/* File: logic/rpbu_pkg.sv */
package rpbu_pkg;

  // ************************************************************
  // Register map and reset values
  // ************************************************************
  localparam logic [15:0] RPBU_ADDR_SLOT0 = 16'hFF38;
  localparam logic [15:0] RPBU_ADDR_SLOT1 = 16'hFF3A;
  localparam logic [15:0] RPBU_ADDR_CTRL = 16'hFF8A;
  localparam logic [15:0] RPBU_SLOT_RESET = 16'h0000;
  localparam logic [7:0] RPBU_CTRL_RESET = 8'h00;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int RPBU_BIT_FLAG0 = 0;
  localparam int RPBU_BIT_EN0 = 1;
  localparam int RPBU_BIT_FLAG1 = 2;
  localparam int RPBU_BIT_EN1 = 3;

  // ************************************************************
  // Branch target
  // ************************************************************
  localparam logic [15:0] RPBU_BRANCH_TARGET = 16'hF7FD;

  // ************************************************************
  // Access sizes
  // ************************************************************
  typedef enum logic [1:0] {
    RPBU_ACC_BIT = 2'b00,
    RPBU_ACC_BYTE = 2'b01,
    RPBU_ACC_WORD = 2'b10
  } rpbu_acc_t;

endpackage

/* File: logic/rpbu_rom_patch.sv */
// Notes on behaviour
// - Two independent patch address slots.
// - Patch addresses accessed as 16-bit words.
// - Reset clears both patch addresses.
// - Enabled address match requests branch to F7FDH.
// - Match sets slot flag, bits 0 and 2.
// - Enable bits 1 and 3 gate matching.
// - Control register takes bit and byte writes.
// - Reset clears the control register.
// - Flag bits ignore byte write data.
`timescale 1ns/1ps
`default_nettype none

module rpbu_rom_patch
  import rpbu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  output logic branch_req,
  output logic [15:0] branch_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire rpbu_acc_t reg_size,
  input wire logic [15:0] reg_addr,
  input wire logic [2:0] reg_bit,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [15:0] patch_address_slot0;
  logic [15:0] patch_address_slot1;
  logic slot0_enable;
  logic slot1_enable;
  logic slot0_match_flag;
  logic slot1_match_flag;
  logic [1:0] match;
  logic wr_slot0;
  logic wr_slot1;
  logic wr_ctrl_byte;
  logic wr_ctrl_bit;
  logic [7:0] ctrl_view;

  assign ctrl_view = {4'h0, slot1_enable, slot1_match_flag,
                      slot0_enable, slot0_match_flag};

  // ************************************************************
  // Helpers
  // ************************************************************
  // One compare for every write strobe keeps the size check beside the address
  // check, so a wrong-size write can never slip into a register.
  function automatic logic rpbu_sel(input logic strobe,
                                    input rpbu_acc_t size,
                                    input rpbu_acc_t want,
                                    input logic [15:0] addr,
                                    input logic [15:0] place);
    return strobe && size == want && addr == place;
  endfunction

  // Both slots share this compare, so they cannot drift apart.
  function automatic logic rpbu_match(input logic valid,
                                      input logic enable,
                                      input logic [15:0] addr,
                                      input logic [15:0] place);
    return valid && enable && addr == place;
  endfunction

  // ************************************************************
  // Decode
  // ************************************************************
  assign wr_slot0 = rpbu_sel(reg_wr, reg_size, RPBU_ACC_WORD, reg_addr,
                             RPBU_ADDR_SLOT0);
  assign wr_slot1 = rpbu_sel(reg_wr, reg_size, RPBU_ACC_WORD, reg_addr,
                             RPBU_ADDR_SLOT1);
  assign wr_ctrl_byte = rpbu_sel(reg_wr, reg_size, RPBU_ACC_BYTE, reg_addr,
                                 RPBU_ADDR_CTRL);
  assign wr_ctrl_bit = rpbu_sel(reg_wr, reg_size, RPBU_ACC_BIT, reg_addr,
                                RPBU_ADDR_CTRL);

  // ************************************************************
  // Comparator
  // ************************************************************
  // The compare is combinational so the branch lands on the same fetch.
  assign match[0] = rpbu_match(fetch_valid, slot0_enable, fetch_addr,
                               patch_address_slot0);
  assign match[1] = rpbu_match(fetch_valid, slot1_enable, fetch_addr,
                               patch_address_slot1);
  assign branch_req = |match;
  assign branch_addr = RPBU_BRANCH_TARGET;

  // ************************************************************
  // Patch address registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      patch_address_slot0 <= RPBU_SLOT_RESET;
      patch_address_slot1 <= RPBU_SLOT_RESET;
    end else begin
      if (wr_slot0) begin
        patch_address_slot0 <= reg_wdata;
      end
      if (wr_slot1) begin
        patch_address_slot1 <= reg_wdata;
      end
    end
  end

  // ************************************************************
  // Enable bits
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot0_enable <= 1'b0;
      slot1_enable <= 1'b0;
    end else if (wr_ctrl_byte) begin
      slot0_enable <= reg_wdata[RPBU_BIT_EN0];
      slot1_enable <= reg_wdata[RPBU_BIT_EN1];
    end else if (wr_ctrl_bit) begin
      if (reg_bit == 3'(RPBU_BIT_EN0)) begin
        slot0_enable <= reg_wdata[0];
      end
      if (reg_bit == 3'(RPBU_BIT_EN1)) begin
        slot1_enable <= reg_wdata[0];
      end
    end
  end

  // ************************************************************
  // Match flags
  // ************************************************************
  // A byte write never touches a flag; only a bit write of zero clears
  // one, so patch handlers can test and clear a single slot. A match
  // in the same cycle as the clear keeps the flag set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot0_match_flag <= 1'b0;
      slot1_match_flag <= 1'b0;
    end else begin
      if (match[0]) begin
        slot0_match_flag <= 1'b1;
      end else if (wr_ctrl_bit && reg_bit == 3'(RPBU_BIT_FLAG0) &&
                   !reg_wdata[0]) begin
        slot0_match_flag <= 1'b0;
      end
      if (match[1]) begin
        slot1_match_flag <= 1'b1;
      end else if (wr_ctrl_bit && reg_bit == 3'(RPBU_BIT_FLAG1) &&
                   !reg_wdata[0]) begin
        slot1_match_flag <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_hit <= 1'b0;
    end else begin
      reg_rdata <= 16'h0000;
      reg_hit <= 1'b0;
      if (reg_rd) begin
        if (reg_addr == RPBU_ADDR_SLOT0) begin
          reg_rdata <= patch_address_slot0;
          reg_hit <= 1'b1;
        end else if (reg_addr == RPBU_ADDR_SLOT1) begin
          reg_rdata <= patch_address_slot1;
          reg_hit <= 1'b1;
        end else if (reg_addr == RPBU_ADDR_CTRL) begin
          if (reg_size == RPBU_ACC_BIT) begin
            reg_rdata <= {15'h0, ctrl_view[reg_bit]};
          end else begin
            reg_rdata <= {8'h00, ctrl_view};
          end
          reg_hit <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_branch_on_match: assert property (@(posedge clk) disable iff (rst)
    (fetch_valid && slot0_enable && fetch_addr == patch_address_slot0)
    |-> branch_req && branch_addr == 16'hF7FD)
    else $error("Enabled slot 0 match gave no branch.");
  a_disabled_no_branch: assert property (@(posedge clk) disable iff (rst)
    (!slot0_enable && !slot1_enable) |-> !branch_req)
    else $error("Branch raised with both slots disabled.");
  a_flag_sets: assert property (@(posedge clk) disable iff (rst)
    match[1] |=> slot1_match_flag)
    else $error("Slot 1 flag not set after match.");
  a_flag_byte_safe: assert property (@(posedge clk) disable iff (rst)
    (wr_ctrl_byte && slot0_match_flag) |=> slot0_match_flag)
    else $error("Byte write changed slot 0 flag.");
  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    (slot0_match_flag && !wr_ctrl_bit) |=> slot0_match_flag)
    else $error("Slot 0 flag dropped without a clear.");
  a_enable_byte: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl_byte |=> slot1_enable == $past(reg_wdata[3]))
    else $error("Byte write missed slot 1 enable.");
  a_addr_load: assert property (@(posedge clk) disable iff (rst)
    wr_slot1 |=> patch_address_slot1 == $past(reg_wdata))
    else $error("Slot 1 address not loaded.");
  a_reset_clear: assert property (@(posedge clk)
    $fell(rst) |-> patch_address_slot0 == 16'h0000
    && ctrl_view == 8'h00)
    else $error("State not cleared by reset.");
  a_reset_slot1: assert property (@(posedge clk)
    $fell(rst) |-> patch_address_slot1 == RPBU_SLOT_RESET)
    else $error("Slot 1 address not cleared by reset.");

  // ************************************************************
  // Branch and flag checks
  // ************************************************************
  a_branch_slot1: assert property (@(posedge clk) disable iff (rst)
    (fetch_valid && slot1_enable && fetch_addr == patch_address_slot1)
    |-> branch_req && branch_addr == RPBU_BRANCH_TARGET)
    else $error("Enabled slot 1 match gave no branch.");
  a_branch_needs_fetch: assert property (@(posedge clk) disable iff (rst)
    !fetch_valid |-> !branch_req)
    else $error("Branch raised without a fetch.");
  a_branch_needs_hit: assert property (@(posedge clk) disable iff (rst)
    branch_req |-> fetch_valid &&
    ((slot0_enable && fetch_addr == patch_address_slot0) ||
     (slot1_enable && fetch_addr == patch_address_slot1)))
    else $error("Branch raised without an enabled match.");
  a_flag0_sets: assert property (@(posedge clk) disable iff (rst)
    match[0] |=> slot0_match_flag)
    else $error("Slot 0 flag not set after match.");
  a_flag1_byte_safe: assert property (@(posedge clk) disable iff (rst)
    (wr_ctrl_byte && !match[1])
    |=> slot1_match_flag == $past(slot1_match_flag))
    else $error("Byte write changed slot 1 flag.");
  a_flag1_sticky: assert property (@(posedge clk) disable iff (rst)
    (slot1_match_flag && !wr_ctrl_bit) |=> slot1_match_flag)
    else $error("Slot 1 flag dropped without a clear.");
  a_flag0_clear: assert property (@(posedge clk) disable iff (rst)
    (wr_ctrl_bit && reg_bit == 3'(RPBU_BIT_FLAG0) && !reg_wdata[0] &&
     !match[0]) |=> !slot0_match_flag)
    else $error("Slot 0 flag not cleared by bit write.");
  a_flag0_no_write: assert property (@(posedge clk) disable iff (rst)
    (!slot0_match_flag && !match[0]) |=> !slot0_match_flag)
    else $error("Slot 0 flag set by software.");

  // ************************************************************
  // Register access checks, then match and flag covers
  // ************************************************************
  a_enable0_byte: assert property (@(posedge clk) disable iff (rst)
    wr_ctrl_byte |=> slot0_enable == $past(reg_wdata[1]))
    else $error("Byte write missed slot 0 enable.");
  a_enable_bit: assert property (@(posedge clk) disable iff (rst)
    (wr_ctrl_bit && reg_bit == 3'(RPBU_BIT_EN1))
    |=> slot1_enable == $past(reg_wdata[0]))
    else $error("Bit write missed slot 1 enable.");
  a_addr0_load: assert property (@(posedge clk) disable iff (rst)
    wr_slot0 |=> patch_address_slot0 == $past(reg_wdata))
    else $error("Slot 0 address not loaded.");
  a_addr0_hold: assert property (@(posedge clk) disable iff (rst)
    !wr_slot0 |=> $stable(patch_address_slot0))
    else $error("Slot 0 address changed without a word write.");
  a_read_slot0: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == RPBU_ADDR_SLOT0)
    |=> reg_hit && reg_rdata == $past(patch_address_slot0))
    else $error("Slot 0 read returned wrong data.");
  a_read_idle: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> !reg_hit && reg_rdata == 16'h0000)
    else $error("Read data shown without a read.");
  a_ctrl_upper: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == RPBU_ADDR_CTRL && reg_size == RPBU_ACC_BYTE)
    |=> reg_rdata[15:4] == 12'h000)
    else $error("Unused control bits read nonzero.");
  c_slot0_fire: cover property (@(posedge clk) disable iff (rst)
    match[0]);
  c_slot1_fire: cover property (@(posedge clk) disable iff (rst)
    match[1]);
  c_flag_cleared: cover property (@(posedge clk) disable iff (rst)
    $fell(slot0_match_flag));
  c_both_flags: cover property (@(posedge clk) disable iff (rst)
    slot0_match_flag && slot1_match_flag);

endmodule

`default_nettype wire

/* File: verif/rom_patch_branch_unit_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Register and fetch tests
// ************************************************************
module rom_patch_branch_unit_tb_top import rpbu_pkg::*;;
  localparam rpbu_acc_t WD = RPBU_ACC_WORD, BY = RPBU_ACC_BYTE;
  localparam rpbu_acc_t BT = RPBU_ACC_BIT;
  logic clk = 0, rst = 1, run = 0, reg_wr = 0, reg_rd = 0;
  logic fetch_valid, branch_req, reg_hit;
  logic [15:0] start_pc = 0, reg_addr = 0, reg_wdata = 0, hit_pc, last_pc;
  logic [15:0] fetch_addr, branch_addr, reg_rdata;
  logic [2:0] reg_bit = 0;
  rpbu_acc_t reg_size = RPBU_ACC_WORD;
  int n_fail = 0, compares = 0, n_br = 0;
  rpbu_rom_patch uut (.clk(clk), .rst(rst), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .branch_req(branch_req),
    .branch_addr(branch_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_size(reg_size), .reg_addr(reg_addr), .reg_bit(reg_bit),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
  rpbu_fetch_model cpu (.clk(clk), .run(run), .start_pc(start_pc),
    .branch_req(branch_req), .branch_addr(branch_addr),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input rpbu_acc_t s,
                     input logic [2:0] b, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_size <= s;
    reg_bit <= b;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input rpbu_acc_t s,
                    input logic [2:0] b, input logic [15:0] e, input logic h);
    acc(1'b0, a, s, b, 16'h0000);
    @(negedge clk);
    chk({h, reg_rdata}, {h, e});
    chk({1'b0, reg_hit, reg_rdata[14:0]}, {1'b0, h, e[14:0]});
  endtask
  // Three fetches from s; a hit, if any, must be the middle one.
  task automatic fetch(input logic [15:0] s, input int n,
                       input logic [15:0] hp, input logic [15:0] lp);
    @(posedge clk);
    start_pc <= s;
    n_br = 0;
    hit_pc = 16'hFFFF;
    @(posedge clk);
    run <= 1'b1;
    repeat (3) @(posedge clk);
    run <= 1'b0;
    chk(17'(n_br), 17'(n));
    chk({1'b0, hit_pc}, {1'b0, hp});
    chk({1'b0, last_pc}, {1'b0, lp});
  endtask
  always @(negedge clk) begin
    if (run) begin
      last_pc = fetch_addr;
      if (branch_req === 1'b1) begin
        n_br++;
        hit_pc = fetch_addr;
        chk({1'b0, branch_addr}, {1'b0, RPBU_BRANCH_TARGET});
      end
    end
  end
  initial begin
    #(2000 * 50);
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(RPBU_ADDR_SLOT0, WD, 3'h0, RPBU_SLOT_RESET, 1'b1);
    rd(RPBU_ADDR_SLOT1, WD, 3'h0, RPBU_SLOT_RESET, 1'b1);
    rd(RPBU_ADDR_CTRL, BY, 3'h0, 16'h0000, 1'b1);
    rd(16'hFF00, BY, 3'h0, 16'h0000, 1'b0);
    acc(1'b1, RPBU_ADDR_SLOT0, WD, 3'h0, 16'h1000);
    acc(1'b1, RPBU_ADDR_SLOT1, WD, 3'h0, 16'h2000);
    rd(RPBU_ADDR_SLOT0, WD, 3'h0, 16'h1000, 1'b1);
    rd(RPBU_ADDR_SLOT1, WD, 3'h0, 16'h2000, 1'b1);
    acc(1'b1, RPBU_ADDR_SLOT0, BY, 3'h0, 16'h5555);
    rd(RPBU_ADDR_SLOT0, WD, 3'h0, 16'h1000, 1'b1);
    fetch(16'h0FFF, 0, 16'hFFFF, 16'h1001);
    acc(1'b1, RPBU_ADDR_CTRL, BY, 3'h0, 16'h000F);
    rd(RPBU_ADDR_CTRL, BY, 3'h0, 16'h000A, 1'b1);
    fetch(16'h0FFF, 1, 16'h1000, RPBU_BRANCH_TARGET);
    rd(RPBU_ADDR_CTRL, BY, 3'h0, 16'h000B, 1'b1);
    fetch(16'h1FFF, 1, 16'h2000, RPBU_BRANCH_TARGET);
    rd(RPBU_ADDR_CTRL, BY, 3'h0, 16'h000F, 1'b1);
    rd(RPBU_ADDR_CTRL, BT, 3'h0, 16'h0001, 1'b1);
    acc(1'b1, RPBU_ADDR_CTRL, BT, 3'h0, 16'h0000);
    rd(RPBU_ADDR_CTRL, BY, 3'h0, 16'h000E, 1'b1);
    acc(1'b1, RPBU_ADDR_CTRL, BY, 3'h0, 16'h0002);
    rd(RPBU_ADDR_CTRL, BY, 3'h0, 16'h0006, 1'b1);
    fetch(16'h1FFF, 0, 16'hFFFF, 16'h2001);
    acc(1'b1, RPBU_ADDR_CTRL, BT, 3'h2, 16'h0000);
    rd(RPBU_ADDR_CTRL, BY, 3'h0, 16'h0002, 1'b1);
    acc(1'b1, RPBU_ADDR_CTRL, BT, 3'h2, 16'h0001);
    rd(RPBU_ADDR_CTRL, BY, 3'h0, 16'h0002, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: verif/rpbu_fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Processor fetch model
// ************************************************************
// The redirect lands one cycle after the request, so a request that
// is missing or late shows up as a wrong next fetch address.
module rpbu_fetch_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [15:0] start_pc,
  input wire logic branch_req,
  input wire logic [15:0] branch_addr,
  output logic fetch_valid,
  output logic [15:0] fetch_addr
);
  logic [15:0] pc;
  always_ff @(posedge clk) begin
    if (!run) begin
      pc <= start_pc;
    end else if (branch_req) begin
      pc <= branch_addr;
    end else begin
      pc <= pc + 16'h0001;
    end
  end
  assign fetch_valid = run;
  // Idle address is scrambled so a stale value cannot fake a match.
  assign fetch_addr = run ? pc : ~pc;
endmodule
`default_nettype wire
